// ===== cmc_pkg.sv
// Package of constants for the core memory configuration register block
`default_nettype none
package cmc_pkg;
    // ==========================================================
    // SFR addresses
    localparam logic [7:0] CMC_ADDR_CONFIG = 8'hAF;
    localparam logic [7:0] CMC_ADDR_SP_HIGH = 8'hB7;
    localparam logic [7:0] CMC_ADDR_SP_LOW = 8'h81;
    // ==========================================================
    // Field positions and reset values
    localparam int CMC_BIT_STACK_EXT = 7;
    localparam int CMC_BIT_XRAM_MAP = 0;
    localparam logic [7:0] CMC_CONFIG_RESET = 8'h00;
    localparam logic [7:0] CMC_CONFIG_IMPL_MASK = 8'h81;
    localparam logic [7:0] CMC_SP_LOW_RESET = 8'h07;
    localparam logic [2:0] CMC_SP_HIGH_RESET = 3'h0;
    // ==========================================================
    // Address space sizes
    localparam int CMC_SP_WIDTH = 11;
    localparam int CMC_XADDR_WIDTH = 24;
    localparam int CMC_INT_XRAM_BITS = 11;
    localparam logic [23:0] CMC_INT_XRAM_LIMIT = 24'h000800;
    // ==========================================================
    // Stack pointer operation codes
    typedef enum logic [1:0] {
        CMC_SP_HOLD = 2'b00,
        CMC_SP_INC = 2'b01,
        CMC_SP_DEC = 2'b11,
        CMC_SP_LOAD = 2'b10
    } cmc_sp_op_t;
endpackage
`default_nettype wire

// ===== cmc_sfr_if.sv
// Interface carrying the internal SFR access bundle
`timescale 1ns/100ps
`default_nettype none
interface cmc_sfr_if;
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic hit;
    modport master (output addr, output wr, output rd, output wdata,
        input rdata, input hit);
    modport slave (input addr, input wr, input rd, input wdata,
        output rdata, output hit);
endinterface
`default_nettype wire

// ===== cmc_stack_ptr.sv
// Stack pointer pair, low byte and gated high byte
`timescale 1ns/100ps
`default_nettype none
module cmc_stack_ptr
    import cmc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic stack_extend_en,
    input wire cmc_sp_op_t sp_op,
    input wire logic [CMC_SP_WIDTH-1:0] sp_load_val,
    cmc_sfr_if.slave sfr,
    output logic [CMC_SP_WIDTH-1:0] stack_ptr
);
    logic [7:0] stack_ptr_low;
    logic [2:0] stack_ptr_high;
    logic [CMC_SP_WIDTH-1:0] next_sp;
    logic wr_low;
    logic wr_high;

    // ==========================================================
    // Pointer step, wrap width depends on the extend bit
    function automatic logic [CMC_SP_WIDTH-1:0] sp_step(
        input logic [CMC_SP_WIDTH-1:0] cur,
        input logic ext,
        input logic up);
        logic [CMC_SP_WIDTH-1:0] full;
        logic [7:0] low;
        full = up ? cur + 11'h001 : cur - 11'h001;
        low = up ? cur[7:0] + 8'h01 : cur[7:0] - 8'h01;
        if (ext) begin
            sp_step = full; // RULE_02
        end else begin
            sp_step = {cur[10:8], low}; // RULE_03
        end
    endfunction

    assign wr_low = sfr.wr && sfr.addr == CMC_ADDR_SP_LOW;
    // High byte writes blocked while extension is off
    assign wr_high = sfr.wr && sfr.addr == CMC_ADDR_SP_HIGH
        && stack_extend_en; // RULE_07

    // Next pointer value
    always_comb begin
        next_sp = {stack_ptr_high, stack_ptr_low};
        case (sp_op)
            CMC_SP_INC: next_sp = sp_step(next_sp, stack_extend_en, 1'b1);
            CMC_SP_DEC: next_sp = sp_step(next_sp, stack_extend_en, 1'b0);
            CMC_SP_LOAD: next_sp = sp_load_val;
            default: next_sp = {stack_ptr_high, stack_ptr_low};
        endcase
        if (wr_low) begin
            next_sp[7:0] = sfr.wdata;
        end
        if (wr_high) begin
            next_sp[10:8] = sfr.wdata[2:0];
        end
        if (!stack_extend_en) begin
            next_sp[10:8] = stack_ptr_high; // RULE_03
        end
    end

    // Low byte register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stack_ptr_low <= CMC_SP_LOW_RESET;
        end else begin
            stack_ptr_low <= next_sp[7:0];
        end
    end

    // High bits frozen while extension is off
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stack_ptr_high <= CMC_SP_HIGH_RESET;
        end else begin
            stack_ptr_high <= next_sp[10:8];
        end
    end

    // Effective pointer hides high bits in classic mode
    assign stack_ptr = stack_extend_en ? {stack_ptr_high, stack_ptr_low}
        : {3'h0, stack_ptr_low};

    // Read mux; high byte reads as absent unless enabled
    always_comb begin
        sfr.rdata = 8'h00;
        sfr.hit = 1'b0;
        if (sfr.addr == CMC_ADDR_SP_LOW) begin
            sfr.rdata = stack_ptr_low;
            sfr.hit = 1'b1;
        end else if (sfr.addr == CMC_ADDR_SP_HIGH && stack_extend_en) begin
            sfr.rdata = {5'h00, stack_ptr_high}; // RULE_07
            sfr.hit = 1'b1;
        end
    end

    property p_high_frozen;
        @(posedge clk) disable iff (!rst_n)
        !stack_extend_en |=> $stable(stack_ptr_high);
    endproperty
    a_high_frozen: assert property (p_high_frozen) // RULE_07
        else $error("high stack bits changed while extension off");

    property p_classic_wrap;
        @(posedge clk) disable iff (!rst_n)
        (!stack_extend_en && sp_op == CMC_SP_INC && !sfr.wr
            && stack_ptr_low == 8'hFF) |=> stack_ptr_low == 8'h00;
    endproperty
    a_classic_wrap: assert property (p_classic_wrap) // RULE_03
        else $error("classic stack did not wrap to zero");

    property p_ext_carry;
        @(posedge clk) disable iff (!rst_n)
        (stack_extend_en && sp_op == CMC_SP_INC && !sfr.wr
            && stack_ptr == 11'h0FF) |=> stack_ptr == 11'h100;
    endproperty
    a_ext_carry: assert property (p_ext_carry) // RULE_02
        else $error("extended stack did not carry into 0100");
endmodule
`default_nettype wire

// ===== cmc_core_memory_config.sv
// Core memory configuration register with stack and XRAM decode
// Behaviour
// RULE_01: After reset the config register reads 00, both features off.
// RULE_02: Stack extend set makes one 11-bit pointer, 00FF carries to 0100.
// RULE_03: Stack extend clear disables the high byte; FF wraps to 00.
// RULE_04: Config bits 1 to 6 are unimplemented, ignore writes, read zero.
// RULE_05: Map bit set sends the lowest 2 kbytes of xdata to on-chip RAM.
// RULE_06: Map bit clear leaves the full 16 MB xdata space off chip.
// RULE_07: The high stack byte is neither read nor written unless extended.
`timescale 1ns/100ps
`default_nettype none
module cmc_core_memory_config
    import cmc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    input wire cmc_sp_op_t sp_op,
    input wire logic [CMC_SP_WIDTH-1:0] sp_load_val,
    output logic [CMC_SP_WIDTH-1:0] stack_ptr,
    input wire logic xdata_req,
    input wire logic [CMC_XADDR_WIDTH-1:0] xdata_addr,
    output logic xdata_internal,
    output logic xdata_external,
    output logic stack_extend_en,
    output logic internal_xram_map_en
);
    logic rst_sync1;
    logic rst_n;
    logic [7:0] core_memory_config;
    logic cfg_sel;
    logic low_region;
    cmc_sfr_if sp_bus();

    // ==========================================================
    // Reset release through two flops
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_sync1 <= 1'b1;
            rst_n <= rst_sync1;
        end
    end

    // ==========================================================
    // Configuration register, only bits 7 and 0 hold state
    assign cfg_sel = sfr_addr == CMC_ADDR_CONFIG;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            core_memory_config <= CMC_CONFIG_RESET; // RULE_01
        end else if (sfr_wr && cfg_sel) begin
            core_memory_config <= CMC_CONFIG_RESET; // RULE_04
            core_memory_config[CMC_BIT_STACK_EXT] <=
                sfr_wdata[CMC_BIT_STACK_EXT];
            core_memory_config[CMC_BIT_XRAM_MAP] <=
                sfr_wdata[CMC_BIT_XRAM_MAP];
        end
    end
    assign stack_extend_en = core_memory_config[CMC_BIT_STACK_EXT];
    assign internal_xram_map_en = core_memory_config[CMC_BIT_XRAM_MAP];

    // ==========================================================
    // Stack pointer block
    assign sp_bus.addr = sfr_addr;
    assign sp_bus.wr = sfr_wr;
    assign sp_bus.rd = sfr_rd;
    assign sp_bus.wdata = sfr_wdata;
    cmc_stack_ptr u_sp (
        .clk(sys_clk),
        .rst_n(rst_n),
        .stack_extend_en(stack_extend_en),
        .sp_op(sp_op),
        .sp_load_val(sp_load_val),
        .sfr(sp_bus.slave),
        .stack_ptr(stack_ptr)
    );

    // Read mux; unclaimed addresses read zero with no hit
    always_comb begin
        if (cfg_sel) begin
            sfr_rdata = core_memory_config;
            sfr_hit = 1'b1;
        end else begin
            sfr_rdata = sp_bus.rdata;
            sfr_hit = sp_bus.hit;
        end
    end

    // ==========================================================
    // External data decode, purely combinational for MOVX timing
    assign low_region =
        xdata_addr[CMC_XADDR_WIDTH-1:CMC_INT_XRAM_BITS] == '0;
    assign xdata_internal = xdata_req && internal_xram_map_en
        && low_region; // RULE_05
    assign xdata_external = xdata_req && !xdata_internal; // RULE_06

    // ==========================================================
    // Checks on reset, register and decode behaviour

    // Config leaves reset at its power-on value
    property p_reset_zero;
        @(posedge sys_clk) $rose(rst_n)
            |-> core_memory_config == CMC_CONFIG_RESET;
    endproperty
    a_reset_zero: assert property (p_reset_zero) // RULE_01
        else $error("config not zero after reset");

    // Bits 6 to 1 never hold state
    property p_unimpl_zero;
        @(posedge sys_clk) disable iff (!rst_n)
        core_memory_config[6:1] == 6'h00;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) // RULE_04
        else $error("unimplemented config bits hold state");

    // Only bits 7 and 0 take the written value
    property p_cfg_write;
        @(posedge sys_clk) disable iff (!rst_n)
        (sfr_wr && cfg_sel) |=>
            core_memory_config == ($past(sfr_wdata) & CMC_CONFIG_IMPL_MASK);
    endproperty
    a_cfg_write: assert property (p_cfg_write) // RULE_04
        else $error("config write not stored");

    // Map on: the bottom 2 kbytes stay on chip
    property p_map_low;
        @(posedge sys_clk) disable iff (!rst_n)
        (xdata_req && internal_xram_map_en && xdata_addr < CMC_INT_XRAM_LIMIT)
            |-> xdata_internal && !xdata_external;
    endproperty
    a_map_low: assert property (p_map_low) // RULE_05
        else $error("low xdata not sent on chip");

    // Map off: every request goes off chip
    property p_map_off;
        @(posedge sys_clk) disable iff (!rst_n)
        (xdata_req && !internal_xram_map_en) |-> xdata_external;
    endproperty
    a_map_off: assert property (p_map_off) // RULE_06
        else $error("xdata not sent off chip with map off");

    // Classic mode: the high byte does not answer reads
    property p_high_hidden;
        @(posedge sys_clk) disable iff (!rst_n)
        (!stack_extend_en && sfr_addr == CMC_ADDR_SP_HIGH) |-> !sfr_hit;
    endproperty
    a_high_hidden: assert property (p_high_hidden) // RULE_07
        else $error("high stack byte visible with extension off");

    // Two-flop release: two edges still in reset with config at default
    sequence s_release_hold;
        (!rst_n && core_memory_config == CMC_CONFIG_RESET) [*2];
    endsequence
    property p_release;
        @(posedge sys_clk) disable iff (!arst_n)
        $rose(arst_n) |-> s_release_hold ##1 rst_n;
    endproperty
    a_release: assert property (p_release) // RULE_01
        else $error("reset release not two edges with config clear");

    // Config keeps its value until software writes it
    property p_cfg_hold;
        @(posedge sys_clk) disable iff (!rst_n)
        !(sfr_wr && cfg_sel) |=> $stable(core_memory_config);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) // RULE_01
        else $error("config changed without a write");

    // Unused config bits read back as zero on a claimed address
    property p_cfg_read;
        @(posedge sys_clk) disable iff (!rst_n)
        cfg_sel |-> sfr_hit && (sfr_rdata & ~CMC_CONFIG_IMPL_MASK) == 8'h00;
    endproperty
    a_cfg_read: assert property (p_cfg_read) // RULE_04
        else $error("unused config bits read nonzero");

    // Low stack byte always reads the live pointer
    property p_low_visible;
        @(posedge sys_clk) disable iff (!rst_n)
        sfr_addr == CMC_ADDR_SP_LOW |-> sfr_hit
            && sfr_rdata == stack_ptr[7:0];
    endproperty
    a_low_visible: assert property (p_low_visible) // RULE_02
        else $error("low stack byte read differs from pointer");

    // Extended: the high byte pairs with the pointer's top bits
    property p_high_visible;
        @(posedge sys_clk) disable iff (!rst_n)
        (stack_extend_en && sfr_addr == CMC_ADDR_SP_HIGH) |-> sfr_hit
            && sfr_rdata == {5'h00, stack_ptr[10:8]};
    endproperty
    a_high_visible: assert property (p_high_visible) // RULE_07
        else $error("high stack byte read differs from pointer");

    // Classic mode never exposes the held upper pointer bits
    property p_classic_top;
        @(posedge sys_clk) disable iff (!rst_n)
        !stack_extend_en |-> stack_ptr[10:8] == 3'h0;
    endproperty
    a_classic_top: assert property (p_classic_top) // RULE_03
        else $error("upper pointer bits seen in classic mode");

    // Above the on-chip window every request goes off chip
    property p_map_high;
        @(posedge sys_clk) disable iff (!rst_n)
        (xdata_req && xdata_addr >= CMC_INT_XRAM_LIMIT)
            |-> xdata_external && !xdata_internal;
    endproperty
    a_map_high: assert property (p_map_high) // RULE_05
        else $error("xdata above window sent on chip");

    // No strobe out of the decoder without a request
    property p_no_req;
        @(posedge sys_clk) disable iff (!rst_n)
        !xdata_req |-> !xdata_internal && !xdata_external;
    endproperty
    a_no_req: assert property (p_no_req) // RULE_06
        else $error("xdata decode active without request");

    // A request picks exactly one target
    property p_one_target;
        @(posedge sys_clk) disable iff (!rst_n)
        xdata_req |-> xdata_internal ^ xdata_external;
    endproperty
    a_one_target: assert property (p_one_target) // RULE_05
        else $error("xdata request not routed to one target");
endmodule
`default_nettype wire

// ===== cmc_core_memory_config_tb_top.sv
// Self-checking testbench for the core memory configuration register
`timescale 1ns/100ps
`default_nettype none
module cmc_core_memory_config_tb_top
    import cmc_pkg::*;
;
    // ==========================================================
    // Signals
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata;
    logic sfr_hit;
    cmc_sp_op_t sp_op = CMC_SP_HOLD;
    logic [10:0] sp_load_val = 11'h000;
    logic [10:0] stack_ptr;
    logic xdata_req = 1'b0;
    logic [23:0] xdata_addr = 24'h000000;
    logic xdata_internal;
    logic xdata_external;
    logic stack_extend_en;
    logic internal_xram_map_en;
    int n_errors = 0;
    int checks = 0;

    cmc_core_memory_config cmc_core_memory_config_i (.sys_clk(sys_clk),
        .arst_n(arst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .sfr_hit(sfr_hit), .sp_op(sp_op), .sp_load_val(sp_load_val),
        .stack_ptr(stack_ptr), .xdata_req(xdata_req),
        .xdata_addr(xdata_addr), .xdata_internal(xdata_internal),
        .xdata_external(xdata_external), .stack_extend_en(stack_extend_en),
        .internal_xram_map_en(internal_xram_map_en));

    // 40 ns period
    always #20 sys_clk = ~sys_clk;

    // ==========================================================
    // Compare and bus tasks
    task automatic chk_word(input string what, input logic [23:0] e,
        input logic [23:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, e, g);
        end
    endtask

    task automatic chk_bit(input string what, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s: expected %b seen %b", what, e, g);
        end
    endtask

    // Write is taken at the second edge, so it is visible right after
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge sys_clk);
        sfr_wr <= 1'b0;
        #1;
    endtask

    // Read data is combinational, so it is sampled once addr settles
    task automatic rd(input logic [7:0] a, input logic [7:0] e,
        input logic h);
        @(posedge sys_clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        #1;
        chk_word("rdata", {16'h0000, e}, {16'h0000, sfr_rdata});
        chk_bit("hit", h, sfr_hit);
    endtask

    task automatic sp(input cmc_sp_op_t op, input logic [10:0] v,
        input logic [10:0] e);
        @(posedge sys_clk);
        sp_op <= op;
        sp_load_val <= v;
        @(posedge sys_clk);
        sp_op <= CMC_SP_HOLD;
        #1;
        chk_word("stack_ptr", {13'h0000, e}, {13'h0000, stack_ptr});
    endtask

    task automatic xd(input logic [23:0] a, input logic internal);
        @(posedge sys_clk);
        xdata_req <= 1'b1;
        xdata_addr <= a;
        #1;
        chk_bit("xdata_internal", internal, xdata_internal);
        chk_bit("xdata_external", !internal, xdata_external);
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    task automatic test_reset;
        rd(CMC_ADDR_CONFIG, 8'h00, 1'b1);
        chk_bit("stack_extend_en", 1'b0, stack_extend_en);
        chk_bit("map_en", 1'b0, internal_xram_map_en);
        chk_word("stack_ptr", 24'h000007, {13'h0000, stack_ptr});
        rd(8'h9F, 8'h00, 1'b0);
        $display("test_reset done");
    endtask

    task automatic test_unused_bits;
        wr(CMC_ADDR_CONFIG, 8'h7E);
        rd(CMC_ADDR_CONFIG, 8'h00, 1'b1);
        wr(CMC_ADDR_CONFIG, 8'hFF);
        rd(CMC_ADDR_CONFIG, 8'h81, 1'b1);
        chk_bit("stack_extend_en", 1'b1, stack_extend_en);
        chk_bit("map_en", 1'b1, internal_xram_map_en);
        $display("test_unused_bits done");
    endtask

    task automatic test_stack;
        wr(CMC_ADDR_SP_HIGH, 8'h03);
        rd(CMC_ADDR_SP_HIGH, 8'h03, 1'b1);
        wr(CMC_ADDR_SP_LOW, 8'h5A);
        rd(CMC_ADDR_SP_LOW, 8'h5A, 1'b1);
        chk_word("stack_ptr", 24'h00035A, {13'h0000, stack_ptr});
        sp(CMC_SP_LOAD, 11'h0FF, 11'h0FF);
        sp(CMC_SP_INC, 11'h000, 11'h100);
        sp(CMC_SP_DEC, 11'h000, 11'h0FF);
        wr(CMC_ADDR_SP_HIGH, 8'h03);
        wr(CMC_ADDR_CONFIG, 8'h01);
        chk_word("stack_ptr", 24'h0000FF, {13'h0000, stack_ptr});
        wr(CMC_ADDR_SP_HIGH, 8'h06);
        rd(CMC_ADDR_SP_HIGH, 8'h00, 1'b0);
        sp(CMC_SP_INC, 11'h000, 11'h000);
        wr(CMC_ADDR_CONFIG, 8'h81);
        rd(CMC_ADDR_SP_HIGH, 8'h03, 1'b1);
        wr(CMC_ADDR_CONFIG, 8'h01);
        $display("test_stack done");
    endtask

    task automatic test_xdata;
        xd(24'h000000, 1'b1);
        xd(24'h0007FF, 1'b1);
        xd(24'h000800, 1'b0);
        wr(CMC_ADDR_CONFIG, 8'h00);
        xd(24'h000000, 1'b0);
        xd(24'hFFFFFF, 1'b0);
        @(posedge sys_clk);
        xdata_req <= 1'b0;
        #1;
        chk_bit("xdata_external", 1'b0, xdata_external);
        chk_bit("xdata_internal", 1'b0, xdata_internal);
        $display("test_xdata done");
    endtask

    // Mid-run reset must clear config and the high stack bits
    task automatic test_reset_again;
        wr(CMC_ADDR_CONFIG, 8'h81);
        @(posedge sys_clk);
        arst_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rd(CMC_ADDR_CONFIG, 8'h00, 1'b1);
        wr(CMC_ADDR_CONFIG, 8'h80);
        rd(CMC_ADDR_SP_HIGH, 8'h00, 1'b1);
        chk_word("stack_ptr", 24'h000007, {13'h0000, stack_ptr});
        $display("test_reset_again done");
    endtask

    // Hang guard, the scenarios need far fewer cycles
    initial begin
        repeat (3000) @(posedge sys_clk);
        n_errors++;
        test_done();
    end

    // Reset for three cycles, then wait out the two-flop release
    initial begin
        repeat (3) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        test_reset();
        test_unused_bits();
        test_stack();
        test_xdata();
        test_reset_again();
        test_done();
    end
endmodule
`default_nettype wire
